// [src/twb_dev.sv]
// two-wire bus engine: arbitrating master plus slave function
// ****************************************************************
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "twb_regs.svh"
module twb_dev #(
	parameter int HALF_CYC = `TWB_HALF_CYC,
	parameter int FREE_CYC = `TWB_FREE_CYC
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	twb_if.dev BUS,
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire twb_pkg::twb_cmd_t CMD_KIND,
	input wire logic [7:0] CMD_DATA,
	input wire logic CMD_NACK,
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic RSP_ACKED,
	output logic RSP_LOST,
	output logic BUS_BUSY,
	input wire logic [6:0] OWN_ADDR,
	input wire logic GCALL_EN,
	input wire logic SLV_READY,
	input wire logic [7:0] SLV_TX_DATA,
	output logic SLV_RX_VALID,
	output logic [7:0] SLV_RX_DATA,
	output logic SLV_SEL,
	output logic SLV_READ
);
	logic [2:0] scl_sync_reg, sda_sync_reg;
	logic scl_reg, sda_reg, scl_d_reg, sda_d_reg;
	logic busy_reg, stop_seen_reg;
	logic [15:0] free_cnt_reg, m_cnt_reg;
	twb_pkg::twb_mst_t m_state_reg;
	logic [3:0] m_bit_reg, s_bit_reg;
	logic [7:0] m_sh_reg, s_sh_reg, rsp_data_reg, rx_data_reg;
	logic m_stop_reg, m_own_reg, m_lost_reg, m_rd_reg, m_nack_reg;
	logic m_acked_reg, m_scl_reg, m_sda_reg, m_ready_reg, rsp_valid_reg;
	logic rsp_acked_reg, rsp_lost_reg;
	twb_pkg::twb_slv_t s_state_reg;
	logic s_sel_reg, s_rw_reg, s_sda_reg, s_hold_reg, s_mack_reg;
	logic rx_valid_reg, scl_oe_reg, sda_oe_reg;

	// ****************************************************************
	// line sampling and condition detection
	// ****************************************************************
	wire scl_rise = scl_reg & ~scl_d_reg;
	wire scl_fall = ~scl_reg & scl_d_reg;
	wire start_det = scl_reg & scl_d_reg & ~sda_reg & sda_d_reg;
	wire stop_det = scl_reg & scl_d_reg & sda_reg & ~sda_d_reg;
	wire half_done = m_cnt_reg == 16'(HALF_CYC - 1);
	wire m_accept = CMD_VALID & m_ready_reg;
	// bit to drive in the current slot; a loser drives nothing
	wire m_drv = ~m_lost_reg & ((m_bit_reg == `TWB_ACK_BIT) ?
		(m_rd_reg & ~m_nack_reg) : (~m_rd_reg & ~m_sh_reg[7]));
	wire m_we_send = (m_bit_reg == `TWB_ACK_BIT) ? m_rd_reg : ~m_rd_reg;
	wire m_high_end = half_done | (m_cnt_reg != 16'h0000 & ~scl_reg);
	wire slv_act = ~(m_own_reg & ~m_lost_reg);
	wire gc_hit = GCALL_EN & (s_sh_reg[7:1] == `TWB_GCALL_ADDR) &
		~s_sh_reg[0];
	wire addr_hit = slv_act & ((s_sh_reg[7:1] == OWN_ADDR) | gc_hit);
	// the clock is let go only a cycle after the data line has settled
	wire sda_moving = sda_oe_reg != (m_sda_reg | s_sda_reg);

	assign BUS.dev_scl_o = 1'b0;
	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_scl_oe = scl_oe_reg;
	assign BUS.dev_sda_oe = sda_oe_reg;
	assign CMD_READY = m_ready_reg;
	assign RSP_VALID = rsp_valid_reg;
	assign RSP_DATA = rsp_data_reg;
	assign RSP_ACKED = rsp_acked_reg;
	assign RSP_LOST = rsp_lost_reg;
	assign BUS_BUSY = busy_reg;
	assign SLV_RX_VALID = rx_valid_reg;
	assign SLV_RX_DATA = rx_data_reg;
	assign SLV_SEL = s_sel_reg;
	assign SLV_READ = s_rw_reg;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			scl_sync_reg <= `TWB_SYNC_IDLE;
			sda_sync_reg <= `TWB_SYNC_IDLE;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], BUS.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], BUS.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_reg <= sda_sync_reg[2];
			end
			scl_d_reg <= scl_reg;
			sda_d_reg <= sda_reg;
			scl_oe_reg <= m_scl_reg | s_hold_reg |
				(scl_oe_reg & sda_moving);
			sda_oe_reg <= m_sda_reg | s_sda_reg;
		end
	end

	// ****************************************************************
	// bus busy tracking
	// ****************************************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			busy_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
			free_cnt_reg <= 16'h0000;
		end else if (start_det) begin
			busy_reg <= 1'b1;
			stop_seen_reg <= 1'b0;
		end else if (stop_det) begin
			stop_seen_reg <= 1'b1;
			free_cnt_reg <= 16'h0000;
		end else if (stop_seen_reg) begin
			if (free_cnt_reg == 16'(FREE_CYC - 1)) begin
				busy_reg <= 1'b0;
				stop_seen_reg <= 1'b0;
			end else begin
				free_cnt_reg <= free_cnt_reg + 16'h0001;
			end
		end
	end

	// ****************************************************************
	// master: conditions and bit slots
	// ****************************************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			m_state_reg <= twb_pkg::TWB_M_IDLE;
			m_cnt_reg <= 16'h0000;
			m_bit_reg <= 4'h0;
			m_sh_reg <= 8'h00;
			m_stop_reg <= 1'b0;
			m_own_reg <= 1'b0;
			m_lost_reg <= 1'b0;
			m_rd_reg <= 1'b0;
			m_nack_reg <= 1'b0;
			m_acked_reg <= 1'b0;
			m_scl_reg <= 1'b0;
			m_sda_reg <= 1'b0;
			m_ready_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 8'h00;
			rsp_acked_reg <= 1'b0;
			rsp_lost_reg <= 1'b0;
		end else begin
			rsp_valid_reg <= 1'b0;
			m_cnt_reg <= m_cnt_reg + 16'h0001;
			m_ready_reg <= (m_state_reg == twb_pkg::TWB_M_IDLE) & ~m_accept &
				(m_own_reg | ~busy_reg);
			case (m_state_reg)
			twb_pkg::TWB_M_IDLE: begin
				m_cnt_reg <= 16'h0000;
				m_bit_reg <= 4'h0;
				// commands other than start are dropped unless the bus is ours
				if (m_accept && CMD_KIND == twb_pkg::TWB_CMD_START) begin
					m_stop_reg <= 1'b0;
					m_rd_reg <= 1'b0;
					m_sh_reg <= CMD_DATA;
					m_own_reg <= 1'b1;
					m_lost_reg <= 1'b0;
					m_state_reg <= twb_pkg::TWB_M_PREP;
				end else if (m_accept && m_own_reg) begin
					m_rd_reg <= CMD_KIND == twb_pkg::TWB_CMD_READ;
					m_nack_reg <= CMD_NACK;
					m_sh_reg <= CMD_DATA;
					m_stop_reg <= CMD_KIND == twb_pkg::TWB_CMD_STOP;
					if (CMD_KIND == twb_pkg::TWB_CMD_STOP) begin
						m_state_reg <= twb_pkg::TWB_M_PREP;
					end else begin
						m_state_reg <= twb_pkg::TWB_M_LOW;
					end
				end
			end
			twb_pkg::TWB_M_PREP: begin
				// scl is still low here when the bus is ours
				m_sda_reg <= m_stop_reg;
				if (half_done) begin
					m_state_reg <= twb_pkg::TWB_M_UP;
				end
			end
			twb_pkg::TWB_M_UP: begin
				m_scl_reg <= 1'b0;
				m_cnt_reg <= 16'h0000;
				if (scl_reg) begin
					m_state_reg <= twb_pkg::TWB_M_HOLD;
				end
			end
			twb_pkg::TWB_M_HOLD: begin
				if (half_done) begin
					m_cnt_reg <= 16'h0000;
					m_state_reg <= twb_pkg::TWB_M_COND;
				end
			end
			twb_pkg::TWB_M_COND: begin
				m_sda_reg <= ~m_stop_reg;
				if (half_done) begin
					m_cnt_reg <= 16'h0000;
					m_own_reg <= ~m_stop_reg;
					m_scl_reg <= ~m_stop_reg;
					m_state_reg <= m_stop_reg ? twb_pkg::TWB_M_IDLE :
						twb_pkg::TWB_M_LOW;
				end
			end
			twb_pkg::TWB_M_LOW: begin
				m_scl_reg <= 1'b1;
				if (m_cnt_reg == 16'h0000) begin
					m_sda_reg <= m_drv;
				end
				if (half_done) begin
					m_state_reg <= twb_pkg::TWB_M_BUP;
				end
			end
			twb_pkg::TWB_M_BUP: begin
				m_scl_reg <= 1'b0;
				m_cnt_reg <= 16'h0000;
				if (scl_reg) begin
					m_state_reg <= twb_pkg::TWB_M_HIGH;
				end
			end
			twb_pkg::TWB_M_HIGH: begin
				if (m_cnt_reg == 16'h0000) begin
					if (m_we_send && !m_sda_reg && !sda_reg) begin
						m_lost_reg <= 1'b1;
					end
					if (m_bit_reg == `TWB_ACK_BIT) begin
						m_acked_reg <= ~sda_reg;
					end else begin
						m_sh_reg <= {m_sh_reg[6:0], sda_reg};
					end
				end
				if (m_high_end) begin
					// a shorter high from another master ends ours too
					m_cnt_reg <= 16'h0000;
					m_scl_reg <= 1'b1;
					m_bit_reg <= m_bit_reg + 4'h1;
					m_state_reg <= twb_pkg::TWB_M_LOW;
					if (m_bit_reg == `TWB_ACK_BIT) begin
						rsp_valid_reg <= 1'b1;
						rsp_data_reg <= m_sh_reg;
						rsp_acked_reg <= m_acked_reg;
						rsp_lost_reg <= m_lost_reg;
						m_state_reg <= twb_pkg::TWB_M_IDLE;
						if (m_lost_reg) begin
							m_scl_reg <= 1'b0;
							m_sda_reg <= 1'b0;
							m_own_reg <= 1'b0;
						end
					end
				end
			end
			default: m_state_reg <= twb_pkg::TWB_M_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// slave: address match, receive and transmit
	// ****************************************************************
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			s_state_reg <= twb_pkg::TWB_S_IDLE;
			s_bit_reg <= 4'h0;
			s_sh_reg <= 8'h00;
			s_sel_reg <= 1'b0;
			s_rw_reg <= 1'b0;
			s_sda_reg <= 1'b0;
			s_hold_reg <= 1'b0;
			s_mack_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
		end else begin
			rx_valid_reg <= 1'b0;
			if (start_det) begin
				s_state_reg <= twb_pkg::TWB_S_ADDR;
				// the clock fall that ends the start is not a data bit
				s_bit_reg <= `TWB_PRE_BIT;
				s_sel_reg <= 1'b0;
				s_sda_reg <= 1'b0;
				s_hold_reg <= 1'b0;
			end else if (stop_det) begin
				s_state_reg <= twb_pkg::TWB_S_IDLE;
				s_sel_reg <= 1'b0;
				s_sda_reg <= 1'b0;
				s_hold_reg <= 1'b0;
			end else if (s_hold_reg) begin
				if (SLV_READY) begin
					s_hold_reg <= 1'b0;
					if (s_state_reg == twb_pkg::TWB_S_TX) begin
						s_sh_reg <= SLV_TX_DATA;
						s_sda_reg <= ~SLV_TX_DATA[7];
					end
				end
			end else if (s_state_reg != twb_pkg::TWB_S_IDLE) begin
				if (scl_rise && s_bit_reg != `TWB_ACK_BIT) begin
					s_sh_reg <= {s_sh_reg[6:0], sda_reg};
				end
				if (scl_rise && s_bit_reg == `TWB_ACK_BIT) begin
					s_mack_reg <= ~sda_reg;
				end
				if (scl_fall) begin
					s_bit_reg <= s_bit_reg + 4'h1;
					if (s_bit_reg == `TWB_LAST_BIT) begin
						case (s_state_reg)
						twb_pkg::TWB_S_ADDR: begin
							s_sel_reg <= addr_hit;
							s_rw_reg <= s_sh_reg[0];
							s_sda_reg <= addr_hit;
							if (!addr_hit) begin
								s_state_reg <= twb_pkg::TWB_S_IDLE;
							end
						end
						twb_pkg::TWB_S_RX: begin
							rx_valid_reg <= 1'b1;
							rx_data_reg <= s_sh_reg;
							s_sda_reg <= 1'b1;
						end
						default: s_sda_reg <= 1'b0;
						endcase
					end else if (s_bit_reg == `TWB_ACK_BIT) begin
						s_bit_reg <= 4'h0;
						s_sda_reg <= 1'b0;
						s_hold_reg <= ~SLV_READY;
						if (s_state_reg == twb_pkg::TWB_S_ADDR) begin
							s_state_reg <= s_rw_reg ? twb_pkg::TWB_S_TX :
								twb_pkg::TWB_S_RX;
						end
						if ((s_state_reg == twb_pkg::TWB_S_ADDR && s_rw_reg) ||
							(s_state_reg == twb_pkg::TWB_S_TX && s_mack_reg)) begin
							s_sh_reg <= SLV_TX_DATA;
							s_sda_reg <= SLV_READY & ~SLV_TX_DATA[7];
						end
						if (s_state_reg == twb_pkg::TWB_S_TX && !s_mack_reg) begin
							s_state_reg <= twb_pkg::TWB_S_IDLE;
							s_hold_reg <= 1'b0;
						end
					end else if (s_state_reg == twb_pkg::TWB_S_TX) begin
						s_sda_reg <= ~s_sh_reg[7];
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// [src/twb_far.sv]
// far-end slave on the two-wire bus
`timescale 1ns/10ps
`default_nettype none
`include "twb_regs.svh"
module twb_far #(
	parameter logic [6:0] FAR_ADDR = 7'h2a
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	twb_if.far BUS,
	input wire logic READY,
	input wire logic [7:0] TX_DATA,
	output logic RX_VALID,
	output logic [7:0] RX_DATA,
	output logic SEL,
	output logic READ
);
	logic [2:0] scl_sync_reg, sda_sync_reg;
	logic scl_reg, sda_reg, scl_d_reg, sda_d_reg;
	twb_pkg::twb_slv_t state_reg;
	logic [3:0] bit_reg;
	logic [7:0] sh_reg, rx_data_reg;
	logic sel_reg, rw_reg, sda_pull_reg, hold_reg, mack_reg, rx_valid_reg;
	logic scl_oe_reg, sda_oe_reg;

	// ****************************************************************
	// sampling; this end never makes start or stop
	// ****************************************************************
	wire scl_rise = scl_reg & ~scl_d_reg;
	wire scl_fall = ~scl_reg & scl_d_reg;
	wire start_det = scl_reg & scl_d_reg & ~sda_reg & sda_d_reg;
	wire stop_det = scl_reg & scl_d_reg & sda_reg & ~sda_d_reg;
	wire hit = sh_reg[7:1] == FAR_ADDR;
	wire load = (state_reg == twb_pkg::TWB_S_ADDR && rw_reg) ||
		(state_reg == twb_pkg::TWB_S_TX && mack_reg);
	// the clock is let go only a cycle after the data line has settled
	wire sda_moving = sda_oe_reg != sda_pull_reg;

	assign BUS.far_scl_o = 1'b0;
	assign BUS.far_sda_o = 1'b0;
	assign BUS.far_scl_oe = scl_oe_reg;
	assign BUS.far_sda_oe = sda_oe_reg;
	assign RX_VALID = rx_valid_reg;
	assign RX_DATA = rx_data_reg;
	assign SEL = sel_reg;
	assign READ = rw_reg;

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			scl_sync_reg <= `TWB_SYNC_IDLE;
			sda_sync_reg <= `TWB_SYNC_IDLE;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], BUS.scl};
			sda_sync_reg <= {sda_sync_reg[1:0], BUS.sda};
			if (scl_sync_reg[1] == scl_sync_reg[2]) begin
				scl_reg <= scl_sync_reg[2];
			end
			if (sda_sync_reg[1] == sda_sync_reg[2]) begin
				sda_reg <= sda_sync_reg[2];
			end
			scl_d_reg <= scl_reg;
			sda_d_reg <= sda_reg;
			scl_oe_reg <= hold_reg |
				(scl_oe_reg & sda_moving);
			sda_oe_reg <= sda_pull_reg;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_reg <= twb_pkg::TWB_S_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			sel_reg <= 1'b0;
			rw_reg <= 1'b0;
			sda_pull_reg <= 1'b0;
			hold_reg <= 1'b0;
			mack_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
			rx_data_reg <= 8'h00;
		end else begin
			rx_valid_reg <= 1'b0;
			if (start_det) begin
				state_reg <= twb_pkg::TWB_S_ADDR;
				// the clock fall that ends the start is not a data bit
				bit_reg <= `TWB_PRE_BIT;
				sel_reg <= 1'b0;
				sda_pull_reg <= 1'b0;
				hold_reg <= 1'b0;
			end else if (stop_det) begin
				state_reg <= twb_pkg::TWB_S_IDLE;
				sel_reg <= 1'b0;
				sda_pull_reg <= 1'b0;
				hold_reg <= 1'b0;
			end else if (hold_reg) begin
				if (READY) begin
					hold_reg <= 1'b0;
					if (state_reg == twb_pkg::TWB_S_TX) begin
						sh_reg <= TX_DATA;
						sda_pull_reg <= ~TX_DATA[7];
					end
				end
			end else if (state_reg != twb_pkg::TWB_S_IDLE) begin
				if (scl_rise && bit_reg != `TWB_ACK_BIT) begin
					sh_reg <= {sh_reg[6:0], sda_reg};
				end
				if (scl_rise && bit_reg == `TWB_ACK_BIT) begin
					mack_reg <= ~sda_reg;
				end
				if (scl_fall) begin
					bit_reg <= bit_reg + 4'h1;
					if (bit_reg == `TWB_LAST_BIT) begin
						case (state_reg)
						twb_pkg::TWB_S_ADDR: begin
							sel_reg <= hit;
							rw_reg <= sh_reg[0];
							sda_pull_reg <= hit;
							if (!hit) begin
								state_reg <= twb_pkg::TWB_S_IDLE;
							end
						end
						twb_pkg::TWB_S_RX: begin
							rx_valid_reg <= 1'b1;
							rx_data_reg <= sh_reg;
							sda_pull_reg <= 1'b1;
						end
						default: sda_pull_reg <= 1'b0;
						endcase
					end else if (bit_reg == `TWB_ACK_BIT) begin
						bit_reg <= 4'h0;
						sda_pull_reg <= 1'b0;
						hold_reg <= ~READY;
						if (state_reg == twb_pkg::TWB_S_ADDR) begin
							state_reg <= rw_reg ? twb_pkg::TWB_S_TX :
								twb_pkg::TWB_S_RX;
						end
						if (load) begin
							sh_reg <= TX_DATA;
							sda_pull_reg <= READY & ~TX_DATA[7];
						end
						// a not-acknowledge from the master ends our sending
						if (state_reg == twb_pkg::TWB_S_TX && !mack_reg) begin
							state_reg <= twb_pkg::TWB_S_IDLE;
							hold_reg <= 1'b0;
						end
					end else if (state_reg == twb_pkg::TWB_S_TX) begin
						sda_pull_reg <= ~sh_reg[7];
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// [src/twb_if.sv]
// shared open-drain clock and data lines between the two ends
`timescale 1ns/10ps
`default_nettype none
interface twb_if;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic far_scl_o;
	logic far_scl_oe;
	logic far_sda_o;
	logic far_sda_oe;
	wire logic scl;
	wire logic sda;
	// ****************************************************************
	// wired-AND with pull-up
	// ****************************************************************
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (far_scl_oe & ~far_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (far_sda_oe & ~far_sda_o));
	modport dev (input scl, sda,
		output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe);
	modport far (input scl, sda,
		output far_scl_o, far_scl_oe, far_sda_o, far_sda_oe);
endinterface
`default_nettype wire

// [src/twb_pkg.sv]
// types of the two-wire bus engine
`default_nettype none
package twb_pkg;
	typedef enum logic [1:0] {
		TWB_CMD_START,
		TWB_CMD_WRITE,
		TWB_CMD_READ,
		TWB_CMD_STOP
	} twb_cmd_t;
	typedef enum logic [2:0] {
		TWB_M_IDLE,
		TWB_M_PREP,
		TWB_M_UP,
		TWB_M_HOLD,
		TWB_M_COND,
		TWB_M_LOW,
		TWB_M_BUP,
		TWB_M_HIGH
	} twb_mst_t;
	typedef enum logic [1:0] {
		TWB_S_IDLE,
		TWB_S_ADDR,
		TWB_S_RX,
		TWB_S_TX
	} twb_slv_t;
endpackage
`default_nettype wire

// [src/twb_regs.svh]
// timing and encoding constants of the two-wire bus engine
`ifndef TWB_REGS_SVH
`define TWB_REGS_SVH

// ****************************************************************
// clock and bit rate
// ****************************************************************
`define TWB_CLK_NS 8
`define TWB_STD_KBPS 100
`define TWB_FAST_KBPS 400
`define TWB_STD_HALF_NS (1000000 / `TWB_STD_KBPS / 2)
`define TWB_FAST_HALF_NS (1000000 / `TWB_FAST_KBPS / 2)
`define TWB_HALF_CYC ((`TWB_STD_HALF_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`define TWB_FAST_CYC ((`TWB_FAST_HALF_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)
`define TWB_FREE_NS 5000
`define TWB_FREE_CYC ((`TWB_FREE_NS + `TWB_CLK_NS - 1) / `TWB_CLK_NS)

// ****************************************************************
// frame layout and reset levels
// ****************************************************************
`define TWB_GCALL_ADDR 7'h00
`define TWB_LAST_BIT 4'h7
`define TWB_ACK_BIT 4'h8
// bit counter value before the clock fall that follows a start
`define TWB_PRE_BIT 4'hf
`define TWB_SYNC_IDLE 3'h7
`endif

// [test/twb_props.sv]
// concurrent checks on the shared two-wire lines
`timescale 1ns/10ps
`default_nettype none
module twb_props #(
	parameter int HALF_CYC = 20
) (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_o,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic far_scl_o,
	input wire logic far_scl_oe,
	input wire logic far_sda_o,
	input wire logic far_sda_oe
);
	logic [15:0] lo_reg;
	logic [15:0] hi_reg;
	// ********
	// phase counters
	// ********
	// saturating, so a long idle bus cannot wrap into a short phase
	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			lo_reg <= 16'h0000;
			hi_reg <= 16'h0000;
		end else begin
			lo_reg <= scl ? 16'h0000 : lo_reg + {15'h0000, ~&lo_reg};
			hi_reg <= !scl ? 16'h0000 : hi_reg + {15'h0000, ~&hi_reg};
		end
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	sequence s_start;
		scl && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $rose(sda);
	endsequence
	chk_pull_only: assert property (!(dev_scl_o | dev_sda_o | far_scl_o | far_sda_o))
		else $error("a line is driven high");
	chk_low_time: assert property ($rose(scl) |-> lo_reg >= HALF_CYC - 1)
		else $error("clock low phase too short");
	chk_high_time: assert property ($fell(scl) |-> hi_reg >= HALF_CYC)
		else $error("clock high phase too short");
	chk_start_hold: assert property (s_start |=> scl [*8])
		else $error("clock pulled too soon after start");
	chk_stop_gap: assert property (s_stop |=> (!(scl && $fell(sda))) [*8])
		else $error("start follows stop without free gap");
	chk_far_stable: assert property ($changed(far_sda_oe) |-> !$past(scl))
		else $error("slave data moved while clock high");
	chk_far_stretch: assert property ($rose(far_scl_oe) |-> !$past(scl))
		else $error("slave pulled clock during high phase");
	chk_no_clash: assert property (scl && far_sda_oe |-> !dev_sda_oe)
		else $error("both ends drive data in one high phase");
	cover property (s_stop);
endmodule
`default_nettype wire

// [test/two_wire_bus_protocol_engine_bench.sv]
// self-checking bench joining the master end to a far slave end
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("unexpected %s: expected %h, seen %h", nm, e, g); \
	end \
end
module two_wire_bus_protocol_engine_bench;
	typedef struct {
		twb_pkg::twb_cmd_t kind;
		logic [7:0] data;
		logic ack;
		logic sel;
	} twb_note_t;
	localparam int HALF = 20;
	localparam int LIM = 4000;
	localparam logic [6:0] FAR = 7'h2a;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	twb_pkg::twb_cmd_t cmd_kind = twb_pkg::TWB_CMD_START;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_nack = 1'b0;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_acked;
	logic rsp_lost;
	logic bus_busy;
	logic far_ready = 1'b1;
	logic [7:0] far_tx = 8'h00;
	logic [7:0] far_rx;
	logic far_sel;
	logic far_read;
	logic far_rx_valid;
	logic slv_sel;
	int far_rx_cnt = 0;
	logic seeded = 1'b0;
	int fails = 0;
	int checks_done = 0;
	twb_note_t note_q[$];
	twb_note_t n;
	twb_if i_twb_if();
	twb_dev #(.HALF_CYC(HALF), .FREE_CYC(10)) i_twb_dev(
		.CLK_SYS(clk_sys), .RSTN(rstn), .BUS(i_twb_if),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind),
		.CMD_DATA(cmd_data), .CMD_NACK(cmd_nack), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .RSP_ACKED(rsp_acked), .RSP_LOST(rsp_lost),
		.BUS_BUSY(bus_busy), .OWN_ADDR(7'h11), .GCALL_EN(1'b0),
		.SLV_READY(1'b1), .SLV_TX_DATA(8'h00), .SLV_RX_VALID(),
		.SLV_RX_DATA(), .SLV_SEL(slv_sel), .SLV_READ());
	twb_far #(.FAR_ADDR(FAR)) i_twb_far(
		.CLK_SYS(clk_sys), .RSTN(rstn), .BUS(i_twb_if), .READY(far_ready),
		.TX_DATA(far_tx), .RX_VALID(far_rx_valid), .RX_DATA(far_rx),
		.SEL(far_sel),
		.READ(far_read));
	twb_props #(.HALF_CYC(HALF)) i_twb_props(
		.CLK_SYS(clk_sys), .RSTN(rstn), .scl(i_twb_if.scl),
		.sda(i_twb_if.sda), .dev_scl_o(i_twb_if.dev_scl_o),
		.dev_scl_oe(i_twb_if.dev_scl_oe), .dev_sda_o(i_twb_if.dev_sda_o),
		.dev_sda_oe(i_twb_if.dev_sda_oe), .far_scl_o(i_twb_if.far_scl_o),
		.far_scl_oe(i_twb_if.far_scl_oe), .far_sda_o(i_twb_if.far_sda_o),
		.far_sda_oe(i_twb_if.far_sda_oe));
	always #4 clk_sys = ~clk_sys;
	// random slave readiness makes the far end stretch the clock
	always @(posedge clk_sys) begin
		far_ready <= !seeded || ($urandom % 4 != 0);
	end
	// ********
	// response monitor
	// ********
	always @(posedge clk_sys) begin
		if (far_rx_valid === 1'b1)
			far_rx_cnt++;
		if (rsp_valid === 1'b1) begin
			if (note_q.size() == 0) begin
				`CHK("spare response", 1'b0, 1'b1)
			end else begin
				n = note_q.pop_front();
				`CHK("byte", n.data, rsp_data)
				`CHK("lost", 1'b0, rsp_lost)
				if (n.kind != twb_pkg::TWB_CMD_READ)
					`CHK("ack", n.ack, rsp_acked)
				if (n.kind == twb_pkg::TWB_CMD_START) begin
					`CHK("busy", 1'b1, bus_busy)
					`CHK("own select", 1'b0, slv_sel)
					`CHK("select", n.sel, far_sel)
					if (n.sel)
						`CHK("direction", n.data[0], far_read)
				end else if (n.kind == twb_pkg::TWB_CMD_WRITE)
					`CHK("far byte", n.data, far_rx)
			end
		end
	end
	task automatic end_sim();
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// holds the request until the edge that samples ready high
	task automatic send(input twb_pkg::twb_cmd_t k, input logic [7:0] d,
		input logic nk, input logic ak, input logic sl);
		int t;
		twb_note_t m;
		t = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_data <= d;
		cmd_nack <= nk;
		do begin
			@(posedge clk_sys);
			t++;
		end while (cmd_ready !== 1'b1 && t < LIM);
		cmd_valid <= 1'b0;
		if (t >= LIM) begin
			fails++;
			end_sim();
		end
		m = '{k, d, ak, sl};
		if (k != twb_pkg::TWB_CMD_STOP)
			note_q.push_back(m);
	endtask
	// ********
	// main sequence
	// ********
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		void'($urandom(90));
		seeded <= 1'b1;
		far_tx <= 8'($urandom);
		@(posedge clk_sys);
		send(twb_pkg::TWB_CMD_START, {FAR, 1'b0}, 1'b0, 1'b1, 1'b1);
		for (int i = 0; i < 3; i++)
			send(twb_pkg::TWB_CMD_WRITE, 8'($urandom), 1'b0, 1'b1, 1'b1);
		send(twb_pkg::TWB_CMD_START, {FAR, 1'b1}, 1'b0, 1'b1, 1'b1);
		send(twb_pkg::TWB_CMD_READ, far_tx, 1'b0, 1'b0, 1'b0);
		send(twb_pkg::TWB_CMD_READ, far_tx, 1'b1, 1'b0, 1'b0);
		send(twb_pkg::TWB_CMD_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
		send(twb_pkg::TWB_CMD_START, {7'h55, 1'b0}, 1'b0, 1'b0, 1'b0);
		send(twb_pkg::TWB_CMD_STOP, 8'h00, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < LIM && (bus_busy !== 1'b0 || note_q.size() != 0); i++)
			@(posedge clk_sys);
		`CHK("idle", 1'b0, bus_busy)
		`CHK("pending", 0, note_q.size())
		`CHK("far bytes", 3, far_rx_cnt)
		end_sim();
	end
endmodule
`default_nettype wire
